// File: pkg/charger_port_cfg.svh
// Purpose: Constants of the charger bus port: address, commands, resets, fields, times.
// Assumes: 25 MHz clk_i.
// Notes: Times are kept in their own unit; cycle counts are derived in the module.
`ifndef CHARGER_PORT_CFG_SVH
`define CHARGER_PORT_CFG_SVH

// ****************************************
// Bus address and command codes
// ****************************************
`define SLAVE_ADDR 7'h09
`define CMD_OPTION 8'h12
`define CMD_CURRENT 8'h14
`define CMD_VOLTAGE 8'h15
`define CMD_INTAKE 8'h3f
`define CMD_MAKER 8'hfe
`define CMD_PART 8'hff

// ****************************************
// Reset values and setting field masks
// ****************************************
`define OPTION_RST 16'hf902
`define CURRENT_RST 16'h0000
`define VOLTAGE_RST 16'h0000
`define INTAKE_RST 16'h1000
`define CURRENT_MASK 16'h1fc0
`define VOLTAGE_MASK 16'h7ff0
`define INTAKE_MASK 16'h1f80

// ****************************************
// Option word fields
// ****************************************
`define OPT_DEGLITCH_BIT 15
`define OPT_WD_HI 14
`define OPT_WD_LO 13
`define OPT_PRESENT_BIT 4
`define WD_CODE_SHORT 2'b01
`define WD_CODE_LONG 2'b11

// ****************************************
// Times
// ****************************************
`define CLK_PERIOD_NS 40
`define MS_NS 1000000
`define DEGLITCH_SHORT_MS 150
`define DEGLITCH_LONG_MS 1300
`define WD_SHORT_MS 44000
`define WD_LONG_MS 175000

`endif

// File: pkg/charger_port_pkg.sv
// Purpose: Types of the charger bus port.
// Assumes: Nothing beyond the cfg header.
// Notes: States are one-hot.
`default_nettype none

package charger_port_pkg;

  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } port_state_t;

endpackage

`default_nettype wire

// File: verilog/charger_port.sv
// Purpose: Two-wire word-access slave port of a battery charge controller, with option,
//   setting and identity words, adapter-good deglitch and charge watchdog.
// Assumes: All pin and analog-status inputs are asynchronous to clk_i; bus clock is far
//   slower than clk_i (two-flop sampling plus edge detection).
// Notes: sda is open drain; sda_oe_o high pulls the line low.
`include "charger_port_cfg.svh"
`default_nettype none

module charger_port
  import charger_port_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
  parameter int unsigned DEGLITCH_SHORT_MS = `DEGLITCH_SHORT_MS,
  parameter int unsigned DEGLITCH_LONG_MS = `DEGLITCH_LONG_MS,
  parameter int unsigned WD_SHORT_MS = `WD_SHORT_MS,
  parameter int unsigned WD_LONG_MS = `WD_LONG_MS,
  // Identity values are arbitrary
  parameter logic [15:0] MAKER_CODE = 16'h5a01,
  parameter logic [15:0] PART_CODE = 16'h00c3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Analog status inputs
  input wire logic supply_ok_i,
  input wire logic adapter_detect_input_i,
  input wire logic adapter_valid_i,
  input wire logic adapter_switch_fet_i,
  input wire logic boost_active_i,
  // Outputs to the charger core
  output logic adapter_good_flag_o,
  output logic charge_suspend_o,
  output logic [15:0] option_word_o,
  output logic [15:0] current_target_word_o,
  output logic [15:0] voltage_target_word_o,
  output logic [15:0] intake_limit_word_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [6:0] in_meta;
  logic [6:0] in_sync;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_meta <= 7'h03;
      in_sync <= 7'h03;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      in_meta <= {boost_active_i, adapter_switch_fet_i, adapter_valid_i,
                  adapter_detect_input_i, supply_ok_i, sda_i, scl_i};
      in_sync <= in_meta;
      scl_q <= in_sync[0];
      sda_q <= in_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic comm_en;
  logic valid_s;
  logic fet_s;
  logic boost_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = in_sync[0];
  assign sda_s = in_sync[1];
  assign comm_en = in_sync[2] & in_sync[3];
  assign valid_s = in_sync[4];
  assign fet_s = in_sync[5];
  assign boost_s = in_sync[6];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = sda_q & ~sda_s & scl_s & scl_q;
  assign stop_det = ~sda_q & sda_s & scl_s & scl_q;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_target_cmd(input logic [7:0] c);
    is_target_cmd = (c == `CMD_CURRENT) || (c == `CMD_VOLTAGE);
  endfunction

  function automatic logic [15:0] read_word(input logic [7:0] c);
    case (c)
      `CMD_OPTION: read_word = option_word_o | (16'(valid_s) << `OPT_PRESENT_BIT);
      `CMD_CURRENT: read_word = current_target_word_o;
      `CMD_VOLTAGE: read_word = voltage_target_word_o;
      `CMD_INTAKE: read_word = intake_limit_word_o;
      `CMD_MAKER: read_word = MAKER_CODE;
      `CMD_PART: read_word = PART_CODE;
      default: read_word = 16'h0000;
    endcase
  endfunction

  // ****************************************
  // Bus protocol engine
  // ****************************************
  port_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] cmd;
  logic [7:0] lo_byte;
  logic [15:0] rd_word;
  logic [1:0] byte_idx;
  logic rw;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] cmd_word;

  // A process, not an assign, so the word also follows the registers the function reads
  always_comb begin
    cmd_word = read_word(cmd);
  end

  // The port only ever drives the line low; the pull-up makes the high level.
  always_ff @(posedge clk_i) begin
    sda_o <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_byte <= 8'h00;
      tx_byte <= 8'h00;
      cmd <= 8'h00;
      lo_byte <= 8'h00;
      rd_word <= 16'h0000;
      byte_idx <= 2'h0;
      rw <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (!comm_en || stop_det) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        if (scl_rise && bit_cnt != 4'h8) begin
          rx_byte <= {rx_byte[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        // Apart from the release on start, stop or lockout, drive changes happen on the clock's falling edge
        if (scl_fall) begin
          case (state)
            ST_ADDR: begin
              if (bit_cnt == 4'h8) begin
                if (rx_byte[7:1] == `SLAVE_ADDR) begin
                  state <= ST_ADDR_ACK;
                  sda_oe_o <= 1'b1;
                  rw <= rx_byte[0];
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
            ST_ADDR_ACK: begin
              bit_cnt <= 4'h0;
              byte_idx <= 2'h0;
              if (rw) begin
                state <= ST_RDATA;
                rd_word <= cmd_word;
                tx_byte <= cmd_word[7:0];
                sda_oe_o <= ~cmd_word[7];
              end else begin
                state <= ST_CMD;
                sda_oe_o <= 1'b0;
              end
            end
            ST_CMD: begin
              if (bit_cnt == 4'h8) begin
                cmd <= rx_byte;
                state <= ST_CMD_ACK;
                sda_oe_o <= 1'b1;
              end
            end
            ST_CMD_ACK: begin
              state <= ST_WDATA;
              sda_oe_o <= 1'b0;
              bit_cnt <= 4'h0;
            end
            ST_WDATA: begin
              if (bit_cnt == 4'h8) begin
                state <= ST_WDATA_ACK;
                sda_oe_o <= 1'b1;
                if (byte_idx == 2'h0) begin
                  lo_byte <= rx_byte;
                end else if (byte_idx == 2'h1) begin
                  wr_stb <= 1'b1;
                  wr_data <= {rx_byte, lo_byte};
                end
              end
            end
            ST_WDATA_ACK: begin
              state <= ST_WDATA;
              sda_oe_o <= 1'b0;
              bit_cnt <= 4'h0;
              if (byte_idx != 2'h2) begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
            ST_RDATA: begin
              if (bit_cnt == 4'h8) begin
                state <= ST_RDATA_ACK;
                sda_oe_o <= 1'b0;
                bit_cnt <= 4'h0;
              end else begin
                tx_byte <= {tx_byte[6:0], 1'b0};
                sda_oe_o <= ~tx_byte[6];
              end
            end
            ST_RDATA_ACK: begin
              // Master ack sampled into rx_byte[0]; a not-ack ends the read
              if (bit_cnt == 4'h1 && !rx_byte[0] && byte_idx == 2'h0) begin
                state <= ST_RDATA;
                byte_idx <= 2'h1;
                bit_cnt <= 4'h0;
                tx_byte <= rd_word[15:8];
                sda_oe_o <= ~rd_word[15];
              end else begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
              end
            end
            default: begin
              state <= ST_IDLE;
              sda_oe_o <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      option_word_o <= `OPTION_RST;
      current_target_word_o <= `CURRENT_RST;
      voltage_target_word_o <= `VOLTAGE_RST;
      intake_limit_word_o <= `INTAKE_RST;
    end else if (wr_stb) begin
      case (cmd)
        `CMD_OPTION: option_word_o <= wr_data & ~(16'h0001 << `OPT_PRESENT_BIT);
        `CMD_CURRENT: current_target_word_o <= wr_data & `CURRENT_MASK;
        `CMD_VOLTAGE: voltage_target_word_o <= wr_data & `VOLTAGE_MASK;
        `CMD_INTAKE: intake_limit_word_o <= wr_data & `INTAKE_MASK;
        default: begin
          // Identity and unknown commands ignore writes
        end
      endcase
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [31:0] ms_cnt;
  logic ms_tick;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 32'(MS_CYCLES - 1)) begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // ****************************************
  // Adapter-good deglitch
  // ****************************************
  logic fet_q;
  logic fet_was_off;
  logic [10:0] deg_cnt;
  logic [10:0] deg_limit;

  // Long delay only once the adapter switch has been off; first plug-in stays short
  assign deg_limit = (fet_was_off && option_word_o[`OPT_DEGLITCH_BIT]) ?
                     11'(DEGLITCH_LONG_MS) : 11'(DEGLITCH_SHORT_MS);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fet_q <= 1'b0;
      fet_was_off <= 1'b0;
    end else begin
      fet_q <= fet_s;
      if (fet_q && !fet_s) begin
        fet_was_off <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      deg_cnt <= 11'h0;
      adapter_good_flag_o <= 1'b0;
    end else if (!valid_s) begin
      deg_cnt <= 11'h0;
      adapter_good_flag_o <= 1'b0;
    end else if (!adapter_good_flag_o) begin
      if (deg_cnt >= deg_limit) begin
        adapter_good_flag_o <= 1'b1;
      end else if (ms_tick) begin
        deg_cnt <= deg_cnt + 11'h1;
      end
    end
  end

  // ****************************************
  // Charge watchdog
  // ****************************************
  logic [1:0] wd_code;
  logic wd_en;
  logic [17:0] wd_limit;
  logic [17:0] wd_cnt;

  assign wd_code = option_word_o[`OPT_WD_HI:`OPT_WD_LO];
  assign wd_en = (wd_code == `WD_CODE_SHORT) || (wd_code == `WD_CODE_LONG);
  assign wd_limit = (boost_s || wd_code == `WD_CODE_LONG) ?
                    18'(WD_LONG_MS) : 18'(WD_SHORT_MS);

  // A target write wins over a same-cycle expiry, so charging is never left suspended
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wd_cnt <= 18'h0;
      charge_suspend_o <= 1'b0;
    end else if (wr_stb && is_target_cmd(cmd)) begin
      wd_cnt <= 18'h0;
      charge_suspend_o <= 1'b0;
    end else if (!wd_en) begin
      wd_cnt <= 18'h0;
      charge_suspend_o <= 1'b0;
    end else if (wd_cnt >= wd_limit) begin
      charge_suspend_o <= 1'b1;
    end else if (ms_tick) begin
      wd_cnt <= wd_cnt + 18'h1;
    end
  end

endmodule

`default_nettype wire

// File: test/charger_port_asserts.sv
// Purpose: Pin and output checks of the charger bus port.
// Assumes: Shortened times handed on by the bind.
// Notes: Sees only the top ports.
`include "charger_port_cfg.svh"
`default_nettype none
module charger_port_asserts #(
  parameter int unsigned MS_CYCLES = 25000,
  parameter int unsigned DEGLITCH_SHORT_MS = 150
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Status
  input wire logic supply_ok_i,
  input wire logic adapter_detect_input_i,
  input wire logic adapter_valid_i,
  input wire logic adapter_good_flag_o,
  input wire logic charge_suspend_o,
  // Words
  input wire logic [15:0] option_word_o,
  input wire logic [15:0] current_target_word_o,
  input wire logic [15:0] voltage_target_word_o,
  input wire logic [15:0] intake_limit_word_o
);
  int unsigned valid_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Saturates so a long insertion never wraps
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !adapter_valid_i) begin
      valid_cnt <= 0;
    end else if (valid_cnt < 100000) begin
      valid_cnt <= valid_cnt + 1;
    end
  end
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_no_start: assert property (scl_i && !sda_oe_o |=> !sda_oe_o)
    else $error("sda pulled while scl high");
  a_data_change: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda changed while scl high");
  a_port_locked: assert property
    (!(supply_ok_i && adapter_detect_input_i) [*5] |-> !sda_oe_o)
    else $error("port drives while locked out");
  a_field_masks: assert property
    ((current_target_word_o & ~`CURRENT_MASK) == 16'h0000 &&
     (voltage_target_word_o & ~`VOLTAGE_MASK) == 16'h0000 &&
     (intake_limit_word_o & ~`INTAKE_MASK) == 16'h0000)
    else $error("bits outside setting fields");
  a_good_drops: assert property (!adapter_valid_i [*4] |-> !adapter_good_flag_o)
    else $error("adapter good stays without adapter");
  a_good_rise: assert property ($rose(adapter_good_flag_o) |->
    valid_cnt >= (DEGLITCH_SHORT_MS - 1) * MS_CYCLES)
    else $error("adapter good rose too early");
  a_wd_off: assert property (!option_word_o[13] [*3] |-> !charge_suspend_o)
    else $error("suspend with watchdog disabled");
  a_write_resume: assert property
    ($changed(current_target_word_o) || $changed(voltage_target_word_o)
     |-> ##[0:2] !charge_suspend_o)
    else $error("target write did not resume");
endmodule
bind charger_port charger_port_asserts #(
  .MS_CYCLES(MS_CYCLES),
  .DEGLITCH_SHORT_MS(DEGLITCH_SHORT_MS)
) u_chk (.clk_i, .rstn_i, .scl_i, .sda_o, .sda_oe_o, .supply_ok_i,
  .adapter_detect_input_i, .adapter_valid_i, .adapter_good_flag_o, .charge_suspend_o,
  .option_word_o, .current_target_word_o, .voltage_target_word_o, .intake_limit_word_o);
`default_nettype wire

// File: test/smbus_master_model.sv
// Purpose: Embedded controller as bus master, word write and word read.
// Assumes: Bus clock of eight clk_i periods; sda has a pull-up.
// Notes: scl stands high between frames.
`include "charger_port_cfg.svh"
`default_nettype none
module smbus_master_model (
  // Clock
  input wire logic clk_i,
  // Bus
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Data set only in the low half, sampled while high
  task automatic bit_io(input logic b, output logic s);
    scl_o = 1'b0;
    w(1);
    pull_o = ~b;
    w(3);
    scl_o = 1'b1;
    w(4);
    s = sda_i;
  endtask
  task automatic start_c;
    pull_o = 1'b1;
    w(4);
  endtask
  task automatic stop_c;
    logic s;
    bit_io(1'b0, s);
    pull_o = 1'b0;
    w(4);
  endtask
  task automatic byte_io(input logic [7:0] b, input logic a, output logic [7:0] r,
                         output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(a, k);
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                            output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start_c();
    byte_io({a, 1'b0}, 1'b1, r, k0);
    byte_io(c, 1'b1, r, k1);
    byte_io(d[7:0], 1'b1, r, k2);
    byte_io(d[15:8], 1'b1, r, k3);
    stop_c();
    ok = !(k0 | k1 | k2 | k3);
  endtask
  task automatic read_word(input logic [7:0] c, output logic [15:0] d,
                           output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, s;
    start_c();
    byte_io({`SLAVE_ADDR, 1'b0}, 1'b1, r, k0);
    byte_io(c, 1'b1, r, k1);
    bit_io(1'b1, s);
    start_c();
    byte_io({`SLAVE_ADDR, 1'b1}, 1'b1, r, k2);
    byte_io(8'hff, 1'b0, d[7:0], s);
    byte_io(8'hff, 1'b1, d[15:8], s);
    stop_c();
    ok = !(k0 | k1 | k2);
  endtask
endmodule
`default_nettype wire

// File: test/charger_port_tb_top.sv
// Purpose: Self-checking bench of the charger bus port.
// Assumes: Times shortened by parameters, 100 clk per ms.
// Notes: Master model drives scl and its pull on sda.
`include "charger_port_cfg.svh"
`default_nettype none
module charger_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAKER = 16'h3c5a; // Arbitrary identity value
  localparam logic [15:0] PART = 16'h0a17; // Arbitrary identity value
  logic clk = 1'b0, rstn, supply, detect, valid, fet, boost, ok;
  logic good, susp, oe, m_oe, scl;
  wire logic sda;
  logic [15:0] opt, cur, volt, intake, rd;
  int failures = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  assign sda = ~(m_oe | oe);
  smbus_master_model u_m (.clk_i(clk), .scl_o(scl), .pull_o(m_oe), .sda_i(sda));
  charger_port #(.MS_CYCLES(100), .DEGLITCH_SHORT_MS(3), .DEGLITCH_LONG_MS(6),
    .WD_SHORT_MS(8), .WD_LONG_MS(20), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_dut (
    .clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
    .supply_ok_i(supply), .adapter_detect_input_i(detect), .adapter_valid_i(valid),
    .adapter_switch_fet_i(fet), .boost_active_i(boost), .adapter_good_flag_o(good),
    .charge_suspend_o(susp), .option_word_o(opt), .current_target_word_o(cur),
    .voltage_target_word_o(volt), .intake_limit_word_o(intake));
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic k);
    u_m.write_word(`SLAVE_ADDR, c, d, ok);
    chk({15'h0, ok}, {15'h0, k});
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    u_m.read_word(c, rd, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(rd, exp);
  endtask
  task automatic insert(input int t0, input int t1);
    valid = 1'b1;
    w(t0);
    chk({15'h0, good}, 16'h0000);
    w(t1);
    chk({15'h0, good}, 16'h0001);
    valid = 1'b0;
    w(5);
  endtask
  task automatic t_regs;
    logic [7:0] cmd [4] = '{8'h12, 8'h14, 8'h15, 8'h3f};
    logic [15:0] exp [4] = '{16'hffef, 16'h1fc0, 16'h7ff0, 16'h1f80};
    chk(opt, 16'hf902);
    chk(cur ^ volt ^ intake, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      wr(cmd[i], 16'hffff, 1'b1);
      rd_chk(cmd[i], exp[i]);
    end
    chk(opt, 16'hffef);
  endtask
  task automatic t_refuse;
    rd_chk(8'hfe, MAKER);
    wr(8'hff, 16'h1234, 1'b1);
    rd_chk(8'hff, PART);
    rd_chk(8'h20, 16'h0000);
    u_m.write_word(7'h0a, 8'h14, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      supply = i[0];
      detect = !i[0];
      w(5);
      wr(8'h14, 16'h0000, 1'b0);
    end
    supply = 1'b1;
    detect = 1'b1;
    w(5);
    rd_chk(8'h14, 16'h1fc0);
  endtask
  task automatic t_watchdog;
    wr(8'h12, 16'h2000, 1'b1);
    wr(8'h14, 16'h0040, 1'b1);
    w(600);
    chk({15'h0, susp}, 16'h0000);
    w(450);
    chk({15'h0, susp}, 16'h0001);
    wr(8'h15, 16'h0010, 1'b1);
    chk({15'h0, susp}, 16'h0000);
    boost = 1'b1;
    wr(8'h14, 16'h0080, 1'b1);
    w(1200);
    chk({15'h0, susp}, 16'h0000);
    w(1000);
    chk({15'h0, susp}, 16'h0001);
    boost = 1'b0;
    wr(8'h12, 16'h6000, 1'b1);
    wr(8'h14, 16'h00c0, 1'b1);
    w(1200);
    chk({15'h0, susp}, 16'h0000);
    w(1000);
    chk({15'h0, susp}, 16'h0001);
    wr(8'h12, 16'h4000, 1'b1);
    chk({15'h0, susp}, 16'h0000);
    wr(8'h12, 16'h0000, 1'b1);
    w(1100);
    chk({15'h0, susp}, 16'h0000);
  endtask
  task automatic t_deglitch;
    fet = 1'b0;
    w(5);
    insert(200, 220);
    wr(8'h12, 16'h8000, 1'b1);
    insert(420, 320);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    rstn = 1'b0;
    supply = 1'b1;
    detect = 1'b1;
    valid = 1'b0;
    fet = 1'b1;
    boost = 1'b0;
    w(6);
    rstn = 1'b1;
    w(5);
    insert(200, 220);
    t_regs();
    t_refuse();
    t_watchdog();
    t_deglitch();
    report_and_stop();
  end
  // Run needs about 0.7 ms
  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
